//--- src/ams_device.sv
// Converter mode and channel sequencer, device end of the serial link
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Decided for this implementation: the scan-selection strobe-and-data port.
`timescale 1ns/1ps
module ams_device #(
	parameter int FULL_WAKE_CYCLES = ams_pkg::AMS_FULL_WAKE_CYC
) (
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	// Serial link
	ams_link_if.dev                link,
	// Scan selection and hardware sleep pin
	input  wire logic              sel_wr,
	input  wire logic [7:0]        sel_data,
	input  wire logic              hw_pd,
	// Status
	output ams_pkg::ams_mode_t     mode,
	output logic [7:0]             scan_sel,
	output logic                   sample_pulse,
	output logic [3:0]             sample_channel,
	output logic                   frame_data_valid,
	output logic                   ref_powered,
	output logic                   analog_ready,
	output logic [7:0]             channel_power
);
	import ams_pkg::*;

	// ------------------------------------------------------------
	// Link synchronisers
	// ------------------------------------------------------------
	logic cs_s1, cs_s2, cs_s3;
	logic sclk_s1, sclk_s2, sclk_s3;
	logic sdi_s1, sdi_s2, sdi_s3, hw_pd_s1, hw_pd_s2;

	// Two flops per pin; third flop finds edges and keeps data in step with them
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			{cs_s1, cs_s2, cs_s3} <= 3'h7;
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{sdi_s1, sdi_s2, sdi_s3} <= 3'h0;
			{hw_pd_s1, hw_pd_s2} <= 2'h0;
		end else begin
			{cs_s1, cs_s2, cs_s3} <= {link.cs_n, cs_s1, cs_s2};
			{sclk_s1, sclk_s2, sclk_s3} <= {link.sclk, sclk_s1, sclk_s2};
			{sdi_s1, sdi_s2, sdi_s3} <= {link.sdi, sdi_s1, sdi_s2};
			{hw_pd_s1, hw_pd_s2} <= {hw_pd, hw_pd_s1};
		end
	end

	// Edge strobes
	wire cs_fall   = cs_s3 & ~cs_s2;
	wire cs_rise   = ~cs_s3 & cs_s2;
	wire sclk_fall = sclk_s3 & ~sclk_s2 & ~cs_s2;

	// ------------------------------------------------------------
	// Command capture
	// ------------------------------------------------------------
	logic [15:0] cmd_sr;
	logic [5:0]  edge_cnt;

	localparam logic [5:0] CMD_EDGES  = 6'(AMS_CMD_BITS);
	localparam logic [5:0] FULL_EDGES = 6'(AMS_FRAME_FULL);

	wire cmd_open   = edge_cnt < CMD_EDGES;
	wire cmd_whole  = ~cmd_open;
	wire frame_long = edge_cnt >= FULL_EDGES;

	// Shift the first 16 bits on falling serial clock edges
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cmd_sr   <= AMS_CMD_KEEP;
			edge_cnt <= 6'h00;
		end else if (cs_fall) begin
			edge_cnt <= 6'h00;
		end else if (sclk_fall) begin
			if (cmd_open)
				cmd_sr <= {cmd_sr[14:0], sdi_s3}; // Bit as it stood before the fall
			if (!frame_long)
				edge_cnt <= edge_cnt + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire is_keep  = cmd_sr == AMS_CMD_KEEP;
	wire is_light = cmd_sr == AMS_CMD_LIGHT;
	wire is_full  = cmd_sr == AMS_CMD_FULL;
	wire is_auto  = cmd_sr == AMS_CMD_AUTO;
	wire is_fixed = ams_is_fixed(cmd_sr);
	wire is_conv  = is_auto | is_fixed;
	wire active   = (mode == AMS_AUTO) | (mode == AMS_FIXED);

	// ------------------------------------------------------------
	// Mode selection at the end of each frame
	// ------------------------------------------------------------
	ams_mode_t next_mode;

	always_comb begin
		next_mode = mode;
		if (cs_rise) begin
			if (!cmd_whole)
				next_mode = AMS_INVALID;
			else if (is_light)
				next_mode = AMS_LIGHT;
			else if (is_full)
				next_mode = AMS_FULL;
			else if (is_auto)
				next_mode = AMS_AUTO;
			else if (is_fixed)
				next_mode = AMS_FIXED;
			else if (is_keep)
				next_mode = mode;
			else if (mode == AMS_FULL)
				next_mode = AMS_LIGHT;
		end
	end

	// Hardware sleep pin: held in full sleep, mode and scan selection back to defaults on release
	logic hw_pd_q;
	wire  hw_release = hw_pd_q & ~hw_pd_s2;

	// Mode register and pin sleep tracking
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode    <= AMS_IDLE;
			hw_pd_q <= 1'b0;
		end else begin
			hw_pd_q <= hw_pd_s2;
			if (hw_pd_s2)
				mode <= AMS_FULL;
			else if (hw_release)
				mode <= AMS_IDLE;
			else
				mode <= next_mode;
		end
	end

	// Scan selection, kept across soft sleep
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			scan_sel <= AMS_SCAN_DEF;
		else if (hw_release)
			scan_sel <= AMS_SCAN_DEF;
		else if (sel_wr)
			scan_sel <= sel_data;
	end

	// ------------------------------------------------------------
	// Channel sequencing
	// ------------------------------------------------------------
	// First selected channel at or above start, wrapping round
	function automatic logic [2:0] find_next(input logic [7:0] sel,
	                                         input logic [3:0] start);
		logic [3:0] idx;
		logic       hit;
		find_next = 3'h0;
		hit       = 1'b0;
		for (int i = 0; i < AMS_NUM_CH; i++) begin
			idx = 4'((int'(start) + i) % AMS_NUM_CH);
			if (!hit && sel[idx[2:0]]) begin
				find_next = idx[2:0];
				hit       = 1'b1;
			end
		end
	endfunction : find_next

	logic       scan_restart;
	logic [3:0] fixed_ch;

	wire [3:0] scan_start = scan_restart ? 4'h0 : (sample_channel + 4'h1);
	wire [2:0] scan_ch    = find_next(scan_sel, scan_start);
	wire       take       = cs_fall & active;

	// Restart request and chosen manual channel, taken at frame end
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			scan_restart <= 1'b1;
			fixed_ch     <= 4'h0;
		end else if (cs_rise && cmd_whole && is_auto) begin
			scan_restart <= 1'b1;
		end else if (cs_rise && cmd_whole && is_fixed) begin
			fixed_ch     <= ams_fixed_ch(cmd_sr);
			scan_restart <= 1'b1;
		end else if (take && mode == AMS_AUTO) begin
			scan_restart <= 1'b0;
		end
	end

	// Sample strobe, channel and data valid at each frame start
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sample_pulse     <= 1'b0;
			sample_channel   <= 4'h0;
			frame_data_valid <= 1'b0;
		end else begin
			sample_pulse <= take;
			if (take && mode == AMS_AUTO)
				sample_channel <= {1'b0, scan_ch};
			else if (take)
				sample_channel <= fixed_ch;
			if (cs_fall)
				frame_data_valid <= active;
		end
	end

	// ------------------------------------------------------------
	// Power and wake-up tracking
	// ------------------------------------------------------------
	localparam logic [19:0] LIGHT_WAKE = 20'(AMS_LIGHT_WAKE_CYC);
	localparam logic [19:0] FULL_WAKE  = 20'(FULL_WAKE_CYCLES);
	logic [19:0] wake_cnt;
	wire leave_light = (mode == AMS_LIGHT) & (next_mode != AMS_LIGHT);
	wire leave_full  = (mode == AMS_FULL) & (next_mode != AMS_FULL) & ~hw_pd_s2;

	// Wake delay after leaving a sleep state
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			wake_cnt <= 20'h00000;
		else if (leave_full || hw_release)
			wake_cnt <= FULL_WAKE;
		else if (leave_light)
			wake_cnt <= LIGHT_WAKE;
		else if (wake_cnt != 20'h00000)
			wake_cnt <= wake_cnt - 20'h00001;
	end

	// Power flags, reference off only in full sleep; data line held low while framed
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ref_powered   <= 1'b1;
			analog_ready  <= 1'b0;
			channel_power <= 8'h00;
			link.sdo      <= 1'b0;
			link.sdo_oe   <= 1'b0;
		end else begin
			ref_powered  <= mode != AMS_FULL;
			analog_ready <= active & (wake_cnt == 20'h00000);
			if (mode == AMS_AUTO)
				channel_power <= scan_sel;
			else if (active)
				channel_power <= AMS_SCAN_DEF;
			else
				channel_power <= 8'h00;
			link.sdo     <= 1'b0;
			link.sdo_oe  <= ~cs_s2;
		end
	end

endmodule : ams_device

//--- src/ams_pkg.sv
// Shared constants and types for the mode sequencer and its host
package ams_pkg;

	// ------------------------------------------------------------
	// Command words
	// ------------------------------------------------------------
	localparam logic [15:0] AMS_CMD_KEEP   = 16'h0000;
	localparam logic [15:0] AMS_CMD_LIGHT  = 16'h8200;
	localparam logic [15:0] AMS_CMD_FULL   = 16'h8300;
	localparam logic [15:0] AMS_CMD_AUTO   = 16'hA000;
	localparam logic [15:0] AMS_CMD_FIXED0 = 16'hC000;
	localparam logic [15:0] AMS_CMD_FIXED7 = 16'hDC00;
	localparam logic [15:0] AMS_CMD_STEP   = 16'h0400;
	localparam logic [15:0] AMS_CMD_AUX    = 16'hE000;

	// ------------------------------------------------------------
	// Frame shape and channels
	// ------------------------------------------------------------
	localparam int          AMS_CMD_BITS   = 16;
	localparam int          AMS_FRAME_FULL = 32;
	localparam int          AMS_NUM_CH     = 8;
	localparam logic [3:0]  AMS_AUX_CH     = 4'h8;
	localparam logic [7:0]  AMS_SCAN_DEF   = 8'hFF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int AMS_CLK_HZ       = 25_000_000;
	localparam int AMS_LIGHT_WAKE_US = 20;
	localparam int AMS_LIGHT_WAKE_CYC =
		(AMS_LIGHT_WAKE_US * (AMS_CLK_HZ / 1_000_000));
	localparam int AMS_FULL_WAKE_MS  = 15;
	localparam int AMS_FULL_WAKE_CYC =
		(AMS_FULL_WAKE_MS * (AMS_CLK_HZ / 1_000));
	localparam int AMS_SCLK_HALF     = 4;
	localparam int AMS_CS_GAP        = 4;

	// ------------------------------------------------------------
	// Operating modes, one-hot
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		AMS_IDLE    = 6'h01,
		AMS_LIGHT   = 6'h02,
		AMS_FULL    = 6'h04,
		AMS_AUTO    = 6'h08,
		AMS_FIXED   = 6'h10,
		AMS_INVALID = 6'h20
	} ams_mode_t;

	// Manual channel word: channel 0..7 or auxiliary input
	function automatic logic ams_is_fixed(input logic [15:0] w);
		ams_is_fixed = (w == AMS_CMD_AUX) ||
			((w >= AMS_CMD_FIXED0) && (w <= AMS_CMD_FIXED7) && (w[9:0] == 10'h000));
	endfunction : ams_is_fixed

	// Channel number carried by a manual channel word
	function automatic logic [3:0] ams_fixed_ch(input logic [15:0] w);
		ams_fixed_ch = (w == AMS_CMD_AUX) ? AMS_AUX_CH : {1'b0, w[12:10]};
	endfunction : ams_fixed_ch

endpackage : ams_pkg

//--- src/ams_link_if.sv
// Serial link between host controller and converter sequencer
`timescale 1ns/1ps
interface ams_link_if;
	logic cs_n;     // Frame select, low during a frame
	logic sclk;     // Serial clock made by the host
	logic sdi;      // Command line, host to device
	logic sdo;      // Data line value, device to host
	logic sdo_oe;   // Device drives data line
	logic sdo_line; // Resolved data line level

	// Undriven data line reads low
	assign sdo_line = sdo_oe ? sdo : 1'b0;

	modport dev  (input cs_n, input sclk, input sdi, output sdo, output sdo_oe);
	modport host (output cs_n, output sclk, output sdi, input sdo_line);
endinterface : ams_link_if

//--- src/ams_host.sv
// Host controller end of the serial link: frames one command word
`timescale 1ns/1ps
module ams_host #(
	parameter int FULL_WAKE_CYCLES = ams_pkg::AMS_FULL_WAKE_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	// Command request
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	input  wire logic        cmd_full,
	output logic             cmd_ready,
	// Completion and results
	output logic             frame_done,
	output logic [15:0]      rx_word,
	output logic             results_trusted,
	// Serial link
	ams_link_if.host         link
);
	import ams_pkg::*;

	typedef enum logic [4:0] {
		AMSH_IDLE = 5'h01,
		AMSH_LOW  = 5'h02,
		AMSH_HIGH = 5'h04,
		AMSH_TAIL = 5'h08,
		AMSH_GAP  = 5'h10
	} amsh_state_t;

	localparam logic [3:0]  HALF      = 4'(AMS_SCLK_HALF);
	localparam logic [9:0]  GAP_SHORT = 10'(AMS_CS_GAP);
	localparam logic [9:0]  GAP_LONG  = 10'(AMS_LIGHT_WAKE_CYC);
	localparam logic [19:0] SETTLE    = 20'(FULL_WAKE_CYCLES);
	localparam logic [5:0]  LEN_SHORT = 6'(AMS_CMD_BITS);
	localparam logic [5:0]  LEN_FULL  = 6'(AMS_FRAME_FULL);

	amsh_state_t state;
	logic [3:0]  div_cnt;
	logic [9:0]  gap_cnt;
	logic [5:0]  bit_cnt;
	logic [5:0]  frame_len;
	logic [31:0] tx_sr;
	logic        long_gap;
	logic        asleep_light;
	logic        asleep_full;
	logic [19:0] settle_cnt;
	logic        sdo_s1, sdo_s2;

	// Request decode
	wire req_conv  = (cmd_word == AMS_CMD_AUTO) | ams_is_fixed(cmd_word);
	wire req_wake  = req_conv & (asleep_light | asleep_full);
	wire req_full  = cmd_full | req_conv;
	wire start     = (state == AMSH_IDLE) & cmd_valid;
	wire last_edge = (bit_cnt + 6'h01) == frame_len;
	assign cmd_ready = state == AMSH_IDLE;

	// Data line synchroniser
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			{sdo_s1, sdo_s2} <= 2'h0;
		else
			{sdo_s1, sdo_s2} <= {link.sdo_line, sdo_s1};
	end

	// Frame sequencer: clock divider, shifting and select timing
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			state      <= AMSH_IDLE;
			link.cs_n  <= 1'b1;
			link.sclk  <= 1'b0;
			link.sdi   <= 1'b0;
			div_cnt    <= 4'h0;
			gap_cnt    <= 10'h000;
			bit_cnt    <= 6'h00;
			frame_len  <= LEN_SHORT;
			tx_sr      <= 32'h00000000;
			rx_word    <= 16'h0000;
			long_gap   <= 1'b0;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			case (state)
				AMSH_IDLE: begin
					if (start) begin
						link.cs_n <= 1'b0;
						link.sdi  <= cmd_word[15];
						tx_sr     <= {cmd_word[14:0], 17'h00000};
						frame_len <= req_full ? LEN_FULL : LEN_SHORT;
						long_gap  <= req_wake;
						bit_cnt   <= 6'h00;
						div_cnt   <= HALF;
						state     <= AMSH_LOW;
					end
				end
				AMSH_LOW: begin
					div_cnt <= div_cnt - 4'h1;
					if (div_cnt == 4'h1) begin
						link.sclk <= 1'b1;
						div_cnt   <= HALF;
						state     <= AMSH_HIGH;
					end
				end
				AMSH_HIGH: begin
					div_cnt <= div_cnt - 4'h1;
					if (div_cnt == 4'h1) begin
						link.sclk <= 1'b0;
						rx_word   <= {rx_word[14:0], sdo_s2};
						bit_cnt   <= bit_cnt + 6'h01;
						div_cnt   <= HALF;
						link.sdi  <= tx_sr[31];
						tx_sr     <= {tx_sr[30:0], 1'b0};
						state     <= last_edge ? AMSH_TAIL : AMSH_LOW;
					end
				end
				AMSH_TAIL: begin
					div_cnt <= div_cnt - 4'h1;
					if (div_cnt == 4'h1) begin
						link.cs_n <= 1'b1;
						link.sdi  <= 1'b0;
						gap_cnt   <= long_gap ? GAP_LONG : GAP_SHORT;
						state     <= AMSH_GAP;
					end
				end
				AMSH_GAP: begin
					gap_cnt <= gap_cnt - 10'h001;
					if (gap_cnt == 10'h001) begin
						frame_done <= 1'b1;
						state      <= AMSH_IDLE;
					end
				end
				default: state <= AMSH_IDLE;
			endcase
		end
	end

	// Sleep tracking and settling time after full sleep
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			asleep_light <= 1'b0;
			asleep_full  <= 1'b0;
			settle_cnt   <= 20'h00000;
		end else begin
			if (settle_cnt != 20'h00000)
				settle_cnt <= settle_cnt - 20'h00001;
			if (start && cmd_word == AMS_CMD_LIGHT) begin
				asleep_light <= 1'b1;
				asleep_full  <= 1'b0;
			end else if (start && cmd_word == AMS_CMD_FULL) begin
				asleep_full  <= 1'b1;
				asleep_light <= 1'b0;
			end else if (start && cmd_word != AMS_CMD_KEEP) begin
				if (asleep_full)
					settle_cnt <= SETTLE;
				asleep_full  <= 1'b0;
				asleep_light <= asleep_full | (asleep_light & ~req_conv);
			end
		end
	end

	// Results usable once awake and settled
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			results_trusted <= 1'b0;
		else
			results_trusted <= ~asleep_light & ~asleep_full & (settle_cnt == 20'h00000);
	end

endmodule : ams_host

//--- bench/ams_link_sva.sv
// Protocol checks on the serial link between host and sequencer
`timescale 1ns/1ps
module ams_link_sva (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	// Link signals
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic sdi,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	input  wire logic sdo_line
);
	import ams_pkg::*;

	// ------------------------------------------------------------
	// Helper state: word rebuilt from the wire, select-high time
	// ------------------------------------------------------------
	logic        sclk_q;
	logic [5:0]  rise_cnt;
	logic [15:0] word;
	logic        asleep;
	logic        need_long;
	logic [9:0]  hi_cnt;

	// Edge and command decode
	wire sclk_rise = !sclk_q && sclk && !cs_n;
	wire is_conv   = (word == AMS_CMD_AUTO) || (word == AMS_CMD_AUX) ||
		((word[15:13] == 3'b110) && (word[9:0] == 10'h000));
	wire cs_rise   = cs_n && (hi_cnt == 10'h000);

	// Track bits, light sleep and the wait owed after it
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sclk_q    <= 1'b0;
			rise_cnt  <= 6'h00;
			word      <= 16'h0000;
			asleep    <= 1'b0;
			need_long <= 1'b0;
			hi_cnt    <= 10'h001;
		end else begin
			sclk_q <= sclk;
			if (!cs_n && (hi_cnt != 10'h000))
				rise_cnt <= 6'h00;
			else if (sclk_rise)
				rise_cnt <= rise_cnt + 6'h01;
			if (sclk_rise && (rise_cnt < 6'h10))
				word <= {word[14:0], sdi};
			if (cs_rise) begin
				asleep    <= (word == AMS_CMD_LIGHT) || (asleep && !is_conv && (word != AMS_CMD_FULL));
				need_long <= is_conv && asleep;
			end
			hi_cnt <= !cs_n ? 10'h000 : ((hi_cnt == 10'h3FF) ? hi_cnt : hi_cnt + 10'h001);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sclk_idle_a: assert property (cs_n |-> !sclk) else $error("clock runs outside frame");
	sdi_idle_a: assert property (cs_n |-> !sdi) else $error("command line high outside");
	sdi_stable_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
		else $error("command bit moved while clock high");
	half_per_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("clock high phase not four cycles");
	bit_count_a: assert property ($rose(cs_n) |-> (rise_cnt == 6'h10) || (rise_cnt == 6'h20))
		else $error("frame length not 16 or 32 clocks");
	cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*4]) else $error("select gap short");
	wake_gap_a: assert property ($fell(cs_n) && need_long |-> hi_cnt >= 10'h1F4)
		else $error("select not held high after wake command");
	oe_on_a: assert property ($fell(cs_n) |-> ##[1:4] sdo_oe) else $error("data line not driven");
	oe_off_a: assert property ($rose(cs_n) |-> ##[1:4] !sdo_oe)
		else $error("data line still driven after frame");
	line_low_a: assert property (sdo_oe |-> !sdo_line) else $error("data line not low");

	// Main scenarios seen
	long_frame_c: cover property ($rose(cs_n) && (rise_cnt == 6'h20));
	short_frame_c: cover property ($rose(cs_n) && (rise_cnt == 6'h10));
	wake_gap_c: cover property ($fell(cs_n) && need_long);
endmodule : ams_link_sva

//--- bench/adc_mode_sequencer_test.sv
// Self-checking bench: host and sequencer joined, plus a bit-banged second link
`timescale 1ns/1ps
module adc_mode_sequencer_test;
	import ams_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic               clk_sys = 1'b0;
	logic               sys_rst;
	logic               cmd_valid, cmd_full, cmd_ready, frame_done, results_trusted;
	logic [15:0]        cmd_word, rx_word;
	logic               sel_wr, sel_wr_b, hw_pd_b, sample_pulse, fdv, fdv_b, ref_powered, ready;
	logic [7:0]         sel_data, sel_data_b, scan_sel, scan_sel_b, channel_power;
	logic [3:0]         sample_channel;
	ams_mode_t          mode, mode_b;
	logic [3:0]         samp_q[$];
	int                 error_cnt = 0;
	int                 num_checks = 0;
	int                 cyc = 0;

	ams_link_if link();
	ams_link_if link_b();

	// Clock
	always #20 clk_sys = ~clk_sys;

	// Design ends and link checker
	ams_host #(.FULL_WAKE_CYCLES(50)) ams_host_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_full(cmd_full), .cmd_ready(cmd_ready),
		.frame_done(frame_done), .rx_word(rx_word), .results_trusted(results_trusted), .link(link));
	ams_device #(.FULL_WAKE_CYCLES(50)) ams_device_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(link), .sel_wr(sel_wr), .sel_data(sel_data), .hw_pd(1'b0), .mode(mode),
		.scan_sel(scan_sel), .sample_pulse(sample_pulse), .sample_channel(sample_channel),
		.frame_data_valid(fdv), .ref_powered(ref_powered), .analog_ready(ready),
		.channel_power(channel_power));
	ams_device #(.FULL_WAKE_CYCLES(50)) ams_device_i2 (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.link(link_b), .sel_wr(sel_wr_b), .sel_data(sel_data_b), .hw_pd(hw_pd_b), .mode(mode_b),
		.scan_sel(scan_sel_b), .sample_pulse(), .sample_channel(), .frame_data_valid(fdv_b),
		.ref_powered(), .analog_ready(), .channel_power());
	ams_link_sva ams_link_sva_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(link.cs_n),
		.sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
		.sdo_line(link.sdo_line));

	// Record every sampled channel; cut a hang short
	always @(posedge clk_sys) begin
		if (sample_pulse === 1'b1)
			samp_q.push_back(sample_channel);
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// One command frame through the host, then let the mode settle
	task automatic send(input logic [15:0] w, input logic full);
		int n;
		n = 0;
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		cmd_full  <= full;
		do @(posedge clk_sys); while (cmd_ready !== 1'b1 && ++n < 100);
		cmd_valid <= 1'b0;
		do @(posedge clk_sys); while (frame_done !== 1'b1 && ++n < 2000);
		if (n >= 2000) begin
			error_cnt++;
			complete_run();
		end
		repeat (3) @(posedge clk_sys);
	endtask : send

	// Frame on the second link, nb clocks long
	task automatic bb_frame(input logic [15:0] w, input int nb);
		int i;
		@(posedge clk_sys);
		link_b.cs_n <= 1'b0;
		link_b.sdi  <= w[15];
		for (i = 1; i <= nb; i++) begin
			repeat (4) @(posedge clk_sys);
			link_b.sclk <= 1'b1;
			repeat (4) @(posedge clk_sys);
			link_b.sclk <= 1'b0;
			link_b.sdi  <= (i < 16) ? w[15 - i] : 1'b0;
		end
		repeat (4) @(posedge clk_sys);
		link_b.cs_n <= 1'b1;
		link_b.sdi  <= 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask : bb_frame

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_auto();
		logic [3:0] exp[5];
		exp = '{4'h0, 4'h2, 4'h5, 4'h0, 4'h2};
		@(posedge clk_sys);
		sel_wr   <= 1'b1;
		sel_data <= 8'h25;
		@(posedge clk_sys);
		sel_wr   <= 1'b0;
		samp_q.delete();
		send(AMS_CMD_AUTO, 1'b1);
		check(16'(mode), 16'(AMS_AUTO));
		repeat (4) send(AMS_CMD_KEEP, 1'b0);
		send(AMS_CMD_AUTO, 1'b1);
		send(AMS_CMD_KEEP, 1'b0);
		check(16'(channel_power), 16'h0025);
		check(16'(samp_q.size()), 16'h0006);
		for (int i = 0; i < 5; i++) check(16'(samp_q[i]), 16'(exp[i]));
		check(16'(samp_q[5]), 16'h0000);
	endtask : t_auto

	task automatic t_fixed();
		logic [3:0] ch;
		for (int n = 0; n <= 8; n++) begin
			ch = (n == 8) ? AMS_AUX_CH : 4'(n);
			samp_q.delete();
			send((n == 8) ? AMS_CMD_AUX : AMS_CMD_FIXED0 + 16'(n) * AMS_CMD_STEP, 1'b1);
			check(16'(mode), 16'(AMS_FIXED));
			send(AMS_CMD_KEEP, 1'b0);
			send(AMS_CMD_KEEP, 1'b0);
			check(16'(samp_q[1]), 16'(ch));
			check(16'(samp_q[2]), 16'(ch));
		end
	endtask : t_fixed

	task automatic t_sleep();
		@(posedge clk_sys);
		sel_wr   <= 1'b1;
		sel_data <= 8'h12;
		@(posedge clk_sys);
		sel_wr   <= 1'b0;
		send(AMS_CMD_LIGHT, 1'b0);
		check(16'(mode), 16'(AMS_LIGHT));
		check(16'(ref_powered), 16'h0001);
		send(AMS_CMD_FIXED0 + 16'h0003 * AMS_CMD_STEP, 1'b1);
		send(AMS_CMD_KEEP, 1'b0);
		check(16'(samp_q[$]), 16'h0003);
		check(16'(ready), 16'h0001);
		check(16'(scan_sel), 16'h0012);
		send(AMS_CMD_FULL, 1'b0);
		check(16'(mode), 16'(AMS_FULL));
		check(16'(ref_powered), 16'h0000);
		check(16'(results_trusted), 16'h0000);
		send(AMS_CMD_KEEP, 1'b1);
		check(16'(mode), 16'(AMS_FULL));
		check(16'(fdv), 16'h0000);
		check(rx_word, 16'h0000);
		send(16'h8100, 1'b0);
		check(16'(mode), 16'(AMS_LIGHT));
		send(AMS_CMD_AUTO, 1'b1);
		check(16'(mode), 16'(AMS_AUTO));
		send(AMS_CMD_KEEP, 1'b0);
		check(16'(scan_sel), 16'h0012);
		check(16'(samp_q[$]), 16'h0001);
		check(16'(results_trusted), 16'h0001);
	endtask : t_sleep

	task automatic t_abort();
		bb_frame(AMS_CMD_FIXED0 + AMS_CMD_STEP, 8);
		check(16'(mode_b), 16'(AMS_INVALID));
		bb_frame(AMS_CMD_KEEP, 32);
		check(16'(mode_b), 16'(AMS_INVALID));
		check(16'(fdv_b), 16'h0000);
		bb_frame(AMS_CMD_FIXED0 + AMS_CMD_STEP, 32);
		check(16'(mode_b), 16'(AMS_FIXED));
		@(posedge clk_sys);
		sel_wr_b   <= 1'b1;
		sel_data_b <= 8'h0F;
		@(posedge clk_sys);
		sel_wr_b   <= 1'b0;
		hw_pd_b    <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check(16'(mode_b), 16'(AMS_FULL));
		hw_pd_b <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check(16'(scan_sel_b), 16'(AMS_SCAN_DEF));
		check(16'(mode_b), 16'(AMS_IDLE));
	endtask : t_abort

	// Main sequence
	initial begin
		sys_rst     = 1'b1;
		cmd_valid   = 1'b0;
		cmd_word    = 16'h0000;
		cmd_full    = 1'b0;
		sel_wr      = 1'b0;
		sel_data    = 8'h00;
		sel_wr_b    = 1'b0;
		sel_data_b  = 8'h00;
		hw_pd_b     = 1'b0;
		link_b.cs_n = 1'b1;
		link_b.sclk = 1'b0;
		link_b.sdi  = 1'b0;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_auto();
		t_fixed();
		t_sleep();
		t_abort();
		complete_run();
	end
endmodule : adc_mode_sequencer_test
